// ==== hdl/dspu_pkg.sv ====
// Package of shared constants for the drive security password unit
//
// Overview of operation
// [RULE1] Opcode F1h with select bits 7,5 sets password
// [RULE2] Opcode F2h with select bits 7,5 unlocks
// [RULE3] User password arms lock, locks at power-on
// [RULE4] Master password stored, lock stays disarmed
// [RULE5] Set sector: control, password 1-16, reserved rest
// [RULE6] Control bit 0 identifier, bit 8 level
// [RULE7] All 32 password bytes stored and compared
// [RULE8] Word 17 revision if master; shown outward
// [RULE9] Revision updated only for 0001h to FFFEh
// [RULE10] User, high: user or master unlocks
// [RULE11] User, maximum: master kept but refused
// [RULE12] Maximum level lost password needs erase only
// [RULE13] Unlock keeps password; reset relocks
// [RULE14] Unlock sector: identifier, password 1-16, reserved
// [RULE15] Master unlock compared only at high level
// [RULE16] User unlock compared with stored user password
// [RULE17] Mismatch aborts, decrements counter starting 5
// [RULE18] Counter zero rejects protected commands until reset
// [RULE19] User unlock with lock disarmed aborts
// [RULE20] Host: abort after sector means mismatch
// [RULE21] Frozen device rejects set and unlock
// [RULE22] Passwords and flags persist; counter reloads
package dspu_pkg;
    // ------------------------------------------------------------
    // Command block
    // ------------------------------------------------------------
    localparam logic [7:0]  CMD_SET_PW    = 8'hf1;
    localparam logic [7:0]  CMD_UNLOCK    = 8'hf2;
    localparam logic [7:0]  DEVSEL_ONES   = 8'ha0;
    localparam logic [7:0]  ST_RDY_ONLY   = 8'h40;
    localparam int          ST_BSY_BIT    = 7;
    localparam int          ST_DRQ_BIT    = 3;
    localparam int          ST_ERR_BIT    = 0;
    localparam int          ER_ABT_BIT    = 2;
    localparam int          ER_UNC_BIT    = 6;
    // ------------------------------------------------------------
    // Parameter sector layout
    // ------------------------------------------------------------
    localparam logic [8:0]  SECT_WORDS    = 9'h100;
    localparam logic [8:0]  W_CTRL        = 9'h000;
    localparam logic [8:0]  W_PW_FIRST    = 9'h001;
    localparam logic [8:0]  W_PW_LAST     = 9'h010;
    localparam logic [8:0]  W_REV         = 9'h011;
    localparam int          PW_WORDS      = 16;
    localparam int          PW_BITS       = 256;
    localparam int          CTL_ID_BIT    = 0;
    localparam int          CTL_LVL_BIT   = 8;
    localparam logic [15:0] REV_MIN       = 16'h0001;
    localparam logic [15:0] REV_MAX       = 16'hfffe;
    localparam logic [15:0] REV_RESET     = 16'h0000;
    localparam logic [2:0]  TRIES_RESET   = 3'h5;
    // ------------------------------------------------------------
    // Host register map, byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0]  REG_CMD       = 8'h00;
    localparam logic [7:0]  REG_PARM      = 8'h04;
    localparam logic [7:0]  REG_STAT      = 8'h08;
    localparam logic [7:0]  REG_PW_BASE   = 8'h40;
    localparam int          CMD_HRST_BIT  = 16;
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DS_IDLE = 2'b00,
        DS_XFER = 2'b01,
        DS_EXEC = 2'b10
    } dspu_dstate_t;
    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_CMD  = 3'b001,
        HS_WAIT = 3'b010,
        HS_SEND = 3'b011,
        HS_END  = 3'b100
    } dspu_hstate_t;
endpackage

// ==== hdl/dspu_link_if.sv ====
// Command block link between host and device ends
`timescale 1ns/1ns
interface dspu_link_if;
    logic        cmd_stb;
    logic [7:0]  cmd;
    logic [7:0]  devsel;
    logic        dat_stb;
    logic [15:0] dat;
    logic        hrst_stb;
    logic        drq;
    logic        done;
    logic [7:0]  status;
    logic [7:0]  error;
    modport dev  (input  cmd_stb, cmd, devsel, dat_stb, dat, hrst_stb,
                  output drq, done, status, error);
    modport host (output cmd_stb, cmd, devsel, dat_stb, dat, hrst_stb,
                  input  drq, done, status, error);
endinterface

// ==== hdl/dspu_sect.sv ====
// Parameter sector capture: control word, password and revision
`timescale 1ns/1ns
module dspu_sect
    import dspu_pkg::*;
(
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               rstn,
    // Incoming words
    input  wire logic               clr,
    input  wire logic               stb,
    input  wire logic [8:0]         idx,
    input  wire logic [15:0]        dat,
    // Captured fields
    output logic      [15:0]        ctrl,
    output logic      [PW_BITS-1:0] pw,
    output logic      [15:0]        rev
);
    import dspu_pkg::*;

    typedef struct packed {
        logic [15:0]        ctrl;
        logic [PW_BITS-1:0] pw;
        logic [15:0]        rev;
    } dspu_sect_t;

    dspu_sect_t q, d;

    // Every password word lands in its own slot
    always_comb begin
        d = q;
        if (clr) begin
            d = '0;
        end else if (stb) begin
            if (idx == W_CTRL) begin
                d.ctrl = dat;
            end
            if (idx == W_REV) begin
                d.rev = dat;
            end
            for (int k = 0; k < PW_WORDS; k++) begin
                if (idx == W_PW_FIRST + 9'(k)) begin
                    d.pw[16*k +: 16] = dat;  // [RULE7]
                end
            end
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign ctrl = q.ctrl;
    assign pw   = q.pw;
    assign rev  = q.rev;
endmodule

// ==== hdl/dspu_dev.sv ====
// Device end: security set password and unlock interpreter
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ns
module dspu_dev
    import dspu_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // Link
    dspu_link_if.dev         link,
    // Drive state
    input  wire logic        frozen,
    input  wire logic        nv_wipe,
    output logic             locked,
    output logic             lock_enabled,
    output logic             max_level,
    output logic [2:0]       tries_left,
    output logic [15:0]      rev_code
);
    import dspu_pkg::*;

    typedef struct packed {
        dspu_dstate_t       st;
        logic [8:0]         widx;
        logic               unlock;
        logic [2:0]         tries;
        logic               locked;
        logic               lock_en;
        logic               max_lvl;
        logic [PW_BITS-1:0] user_pw;
        logic [PW_BITS-1:0] mast_pw;
        logic [15:0]        rev;
        logic [7:0]         status;
        logic [7:0]         error;
        logic               done;
    } dspu_dev_t;

    dspu_dev_t          q, d;
    logic [15:0]        s_ctrl;
    logic [PW_BITS-1:0] s_pw;
    logic [15:0]        s_rev;
    logic               sel_ok;
    logic               known;
    logic               id_master;
    logic               abort;

    // ------------------------------------------------------------
    // Sector capture
    // ------------------------------------------------------------
    dspu_sect u_sect (
        .core_clk (core_clk),
        .rstn     (rstn),
        .clr      (link.cmd_stb),
        .stb      (link.dat_stb && q.st == DS_XFER),
        .idx      (q.widx),
        .dat      (link.dat),
        .ctrl     (s_ctrl),
        .pw       (s_pw),
        .rev      (s_rev)
    );

    // Opcode and select decode
    assign sel_ok = (link.devsel & DEVSEL_ONES) == DEVSEL_ONES;
    assign known  = link.cmd == CMD_SET_PW || link.cmd == CMD_UNLOCK;
    assign id_master = s_ctrl[CTL_ID_BIT];  // [RULE6]

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    always_comb begin
        d      = q;
        d.done = 1'b0;
        abort  = 1'b0;
        unique case (q.st)
            DS_IDLE: begin
                if (link.cmd_stb) begin
                    d.unlock = link.cmd == CMD_UNLOCK;
                    d.widx   = W_CTRL;
                    d.error  = '0;
                    // Refused before the sector moves
                    if (!known || !sel_ok || frozen || q.tries == 3'h0) begin
                        abort = 1'b1;  // [RULE1] [RULE2] [RULE18] [RULE21]
                    end else begin
                        d.st = DS_XFER;
                        d.status = ST_RDY_ONLY;
                        d.status[ST_BSY_BIT] = 1'b1;
                        d.status[ST_DRQ_BIT] = 1'b1;
                    end
                end
            end
            DS_XFER: begin
                // One full sector is taken, reserved words ignored
                if (link.dat_stb) begin  // [RULE5] [RULE14]
                    d.widx = q.widx + 9'h001;
                    if (q.widx == SECT_WORDS - 9'h001) begin
                        d.st = DS_EXEC;
                        d.status[ST_DRQ_BIT] = 1'b0;
                    end
                end
            end
            DS_EXEC: begin
                d.st = DS_IDLE;
                if (!q.unlock) begin
                    if (id_master) begin
                        d.mast_pw = s_pw;  // [RULE4] [RULE7]
                        // Only codes inside the valid span replace it
                        if (s_rev >= REV_MIN && s_rev <= REV_MAX) begin
                            d.rev = s_rev;  // [RULE8] [RULE9]
                        end
                    end else begin
                        // Armed now, locked at the next power-on
                        d.user_pw = s_pw;  // [RULE3] [RULE10] [RULE11]
                        d.lock_en = 1'b1;  // [RULE3]
                        d.max_lvl = s_ctrl[CTL_LVL_BIT];  // [RULE6]
                    end
                end else if (id_master && q.max_lvl) begin
                    abort = 1'b1;  // [RULE11] [RULE12] [RULE15]
                end else if (!id_master && !q.lock_en) begin
                    abort = 1'b1;  // [RULE19]
                end else if (s_pw == (id_master ? q.mast_pw : q.user_pw)) begin
                    d.locked = 1'b0;  // [RULE10] [RULE13] [RULE15] [RULE16]
                end else begin
                    abort   = 1'b1;  // [RULE17]
                    d.tries = q.tries - 3'h1;  // [RULE17]
                end
                d.status = ST_RDY_ONLY;
                d.done   = 1'b1;
            end
            default: d.st = DS_IDLE;
        endcase
        // Aborted completion reports the abort flag
        if (abort) begin
            d.st     = DS_IDLE;
            d.status = ST_RDY_ONLY;
            d.status[ST_ERR_BIT] = 1'b1;
            d.error  = '0;
            d.error[ER_ABT_BIT] = 1'b1;
            d.done   = 1'b1;
        end
        // Hard reset relocks and reloads the counter
        if (link.hrst_stb) begin
            d.st     = DS_IDLE;
            d.locked = q.lock_en;  // [RULE13]
            d.tries  = TRIES_RESET;  // [RULE18]
            d.status = ST_RDY_ONLY;
            d.error  = '0;
            d.done   = 1'b0;
        end
        // Factory wipe of the persistent store
        if (nv_wipe) begin
            d.lock_en = 1'b0;
            d.max_lvl = 1'b0;
            d.locked  = 1'b0;
            d.user_pw = '0;
            d.mast_pw = '0;
            d.rev     = REV_RESET;
        end
    end

    // ------------------------------------------------------------
    // State register; persistent fields survive power-on reset
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            q.st     <= DS_IDLE;
            q.widx   <= '0;
            q.unlock <= 1'b0;
            q.tries  <= TRIES_RESET;  // [RULE22] [RULE17]
            q.locked <= q.lock_en;  // [RULE3] [RULE13]
            q.status <= ST_RDY_ONLY;
            q.error  <= '0;
            q.done   <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.drq     = q.status[ST_DRQ_BIT];
    assign link.done    = q.done;
    assign link.status  = q.status;
    assign link.error   = q.error;
    assign locked       = q.locked;
    assign lock_enabled = q.lock_en;
    assign max_level    = q.max_lvl;
    assign tries_left   = q.tries;
    assign rev_code     = q.rev;  // [RULE8]
endmodule

// ==== hdl/dspu_host.sv ====
// Host end: issues security commands from Wishbone registers
`timescale 1ns/1ns
module dspu_host
    import dspu_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Link
    dspu_link_if.host        link
);
    import dspu_pkg::*;

    typedef struct packed {
        dspu_hstate_t      st;
        logic [15:0][15:0] pw;
        logic [15:0]       ctrl;
        logic [15:0]       rev;
        logic [7:0]        cmd;
        logic [7:0]        devsel;
        logic [8:0]        cnt;
        logic              cmd_stb;
        logic              hrst;
        logic              dat_stb;
        logic [15:0]       dat;
        logic              sent;
        logic              done;
        logic              aborted;
        logic              mismatch;
        logic              other;
        logic [7:0]        dstat;
        logic [7:0]        derr;
        logic              ack;
        logic [31:0]       rdat;
    } dspu_host_t;

    dspu_host_t q, d;
    logic       wr;
    logic       rd;
    logic [15:0] word;

    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !q.ack;
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !q.ack;

    // Sector word for the current count
    always_comb begin
        word = 16'h0000;
        if (q.cnt == W_CTRL) begin
            word = q.ctrl;
        end else if (q.cnt >= W_PW_FIRST && q.cnt <= W_PW_LAST) begin
            word = q.pw[4'(q.cnt - W_PW_FIRST)];
        end else if (q.cnt == W_REV) begin
            word = q.rev;
        end
    end

    // ------------------------------------------------------------
    // Register access and command sequencer
    // ------------------------------------------------------------
    always_comb begin
        d         = q;
        d.ack     = wb_cyc_i && wb_stb_i && !q.ack;
        d.cmd_stb = 1'b0;
        d.hrst    = 1'b0;
        d.dat_stb = 1'b0;
        if (wr && wb_sel_i == 4'hf) begin
            if (wb_adr_i == REG_CMD && q.st == HS_IDLE) begin
                if (wb_dat_i[CMD_HRST_BIT]) begin
                    d.hrst = 1'b1;
                end else begin
                    d.cmd    = wb_dat_i[7:0];
                    d.devsel = wb_dat_i[15:8];
                    d.st     = HS_CMD;
                    d.done   = 1'b0;
                    d.sent   = 1'b0;
                    d.aborted  = 1'b0;
                    d.mismatch = 1'b0;
                    d.other    = 1'b0;
                end
            end else if (wb_adr_i == REG_PARM) begin
                d.ctrl = wb_dat_i[15:0];
                d.rev  = wb_dat_i[31:16];
            end else if (wb_adr_i >= REG_PW_BASE) begin
                if (wb_adr_i[7:6] == 2'b01) begin
                    d.pw[wb_adr_i[5:2]] = wb_dat_i[15:0];
                end
            end
        end
        if (rd) begin
            d.rdat = 32'h0000_0000;
            if (wb_adr_i == REG_CMD) begin
                d.rdat = {16'h0000, q.devsel, q.cmd};
            end else if (wb_adr_i == REG_PARM) begin
                d.rdat = {q.rev, q.ctrl};
            end else if (wb_adr_i == REG_STAT) begin
                d.rdat = {8'h00, q.derr, q.dstat, 3'h0, q.other,
                          q.mismatch, q.aborted, q.done,
                          q.st != HS_IDLE};
            end else if (wb_adr_i[7:6] == 2'b01) begin
                d.rdat = {16'h0000, q.pw[wb_adr_i[5:2]]};
            end
        end
        unique case (q.st)
            HS_IDLE, HS_END: begin
            end
            HS_CMD: begin
                d.cmd_stb = 1'b1;  // [RULE1] [RULE2]
                d.st      = HS_WAIT;
            end
            HS_WAIT: begin
                if (link.drq) begin
                    d.st  = HS_SEND;
                    d.cnt = W_CTRL;
                end
            end
            HS_SEND: begin
                // Whole sector, words after the revision word sent as zero
                if (q.cnt == SECT_WORDS) begin  // [RULE5] [RULE14]
                    d.st   = HS_END;
                    d.sent = 1'b1;
                end else begin
                    d.dat_stb = 1'b1;
                    d.dat     = word;
                    d.cnt     = q.cnt + 9'h001;
                end
            end
            default: d.st = HS_IDLE;
        endcase
        // Completion, classified by whether the sector went out
        if (link.done && q.st != HS_IDLE && q.st != HS_CMD) begin
            d.st      = HS_IDLE;
            d.done    = 1'b1;
            d.dstat   = link.status;
            d.derr    = link.error;
            d.aborted = link.error[ER_ABT_BIT];
            d.mismatch = link.error[ER_ABT_BIT] && d.sent;  // [RULE20]
            d.other    = link.error[ER_ABT_BIT] && !d.sent;  // [RULE20]
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign wb_ack_o      = q.ack;
    assign wb_dat_o      = q.rdat;
    assign link.cmd_stb  = q.cmd_stb;
    assign link.cmd      = q.cmd;
    assign link.devsel   = q.devsel;
    assign link.dat_stb  = q.dat_stb;
    assign link.dat      = q.dat;
    assign link.hrst_stb = q.hrst;
endmodule

// ==== verif/dspu_props.sv ====
// Checker of the command link between host and device ends
`timescale 1ns/1ns
module dspu_props
    import dspu_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // Host to device
    input  wire logic        cmd_stb,
    input  wire logic [7:0]  cmd,
    input  wire logic [7:0]  devsel,
    input  wire logic        dat_stb,
    input  wire logic [15:0] dat,
    input  wire logic        hrst_stb,
    // Device to host
    input  wire logic        drq,
    input  wire logic        done,
    input  wire logic [7:0]  status,
    input  wire logic [7:0]  error
);
    logic [8:0] wc_q;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // Counts sector words taken while the device requests data
    always_ff @(posedge core_clk) begin
        if (!rstn || cmd_stb)
            wc_q <= 9'h000;
        else if (dat_stb && drq)
            wc_q <= wc_q + 9'h001;
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    chk_bad_opcode: assert property (cmd_stb && cmd != CMD_SET_PW &&
        cmd != CMD_UNLOCK |=> done && error[ER_ABT_BIT] && !drq)
        else $error("unknown opcode not aborted");
    chk_bad_select: assert property (cmd_stb &&
        (devsel & DEVSEL_ONES) != DEVSEL_ONES |=> done && status[ST_ERR_BIT])
        else $error("bad select not rejected");
    chk_cmd_answer: assert property (cmd_stb |=> drq != done)
        else $error("command unanswered");
    chk_sector_len: assert property ($fell(drq) |-> wc_q == SECT_WORDS)
        else $error("sector length wrong");
    chk_exec_done: assert property ($fell(drq) |=> done)
        else $error("no done after sector");
    chk_done_pulse: assert property (done |=> !done)
        else $error("done too long");
    chk_abort_err: assert property (done |->
        status[ST_ERR_BIT] == error[ER_ABT_BIT])
        else $error("error and abort disagree");
    chk_unc_clear: assert property (done |->
        !error[ER_UNC_BIT] && !status[ST_BSY_BIT])
        else $error("done busy or uncorrectable");
    cover property ($fell(drq));
    cover property (done && error[ER_ABT_BIT]);
    cover property (done && !status[ST_ERR_BIT]);
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench: host and device ends joined by the link
`timescale 1ns/1ns
module tb_top
    import dspu_pkg::*;
;
    typedef struct packed {
        logic hr; logic [7:0] op; logic [15:0] ctl; logic [15:0] rv;
        logic [7:0] key; logic bad; logic command_aborted_flag; logic lk; logic le;
        logic [2:0] tr;
    } dspu_row_t;
    localparam logic [7:0] KA = 8'ha5;
    localparam logic [7:0] KB = 8'h3c;
    localparam dspu_row_t ROWS [8] = '{
        '{1,CMD_SET_PW,16'h0001,16'h1234,KA,0,0,0,0,3'h5},
        '{0,CMD_SET_PW,16'h0001,16'hffff,KA,0,0,0,0,3'h5},
        '{0,CMD_SET_PW,16'h0000,16'h5555,KB,0,0,0,1,3'h5},
        '{1,CMD_UNLOCK,16'h0000,16'h0000,KB,1,1,1,1,3'h4},
        '{0,CMD_UNLOCK,16'h0001,16'h0000,KA,0,0,0,1,3'h4},
        '{1,CMD_UNLOCK,16'h0000,16'h0000,KB,0,0,0,1,3'h5},
        '{0,CMD_SET_PW,16'h0100,16'h7777,KB,0,0,0,1,3'h5},
        '{1,CMD_UNLOCK,16'h0001,16'h0000,KA,0,1,1,1,3'h5}};
    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [31:0] wb_wdat = 32'h0;
    logic [31:0] wb_rdat;
    logic        wb_ack;
    logic        frozen = 1'b0;
    logic        nv_wipe = 1'b0;
    logic        locked;
    logic        lock_enabled;
    logic        max_level;
    logic [2:0]  tries_left;
    logic [15:0] rev_code;
    int          num_errors = 0;
    int          total_checks = 0;
    // Clock of 4 ns
    always #2 core_clk = ~core_clk;
    // ------------------------------------------------------------
    // Design ends and checker
    // ------------------------------------------------------------
    dspu_link_if u_dspu_link_if ();
    dspu_host u_dspu_host (.core_clk(core_clk), .rstn(rstn),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .link(u_dspu_link_if));
    dspu_dev u_dspu_dev (.core_clk(core_clk), .rstn(rstn),
        .link(u_dspu_link_if), .frozen(frozen), .nv_wipe(nv_wipe),
        .locked(locked), .lock_enabled(lock_enabled),
        .max_level(max_level), .tries_left(tries_left),
        .rev_code(rev_code));
    dspu_props u_dspu_props (.core_clk(core_clk), .rstn(rstn),
        .cmd_stb(u_dspu_link_if.cmd_stb), .cmd(u_dspu_link_if.cmd),
        .devsel(u_dspu_link_if.devsel), .dat(u_dspu_link_if.dat),
        .dat_stb(u_dspu_link_if.dat_stb), .drq(u_dspu_link_if.drq),
        .hrst_stb(u_dspu_link_if.hrst_stb), .done(u_dspu_link_if.done),
        .status(u_dspu_link_if.status), .error(u_dspu_link_if.error));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic finish_test;
        $display("Checks %0d, errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (!ok) begin
            num_errors++;
            $display("Error %0t: %s", $time, m);
        end
    endtask
    // One classic Wishbone cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge core_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_wdat <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk(1'b0, "no bus ack");
            finish_test();
        end
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic hard_rst;
        logic [31:0] q;
        wb(1'b1, REG_CMD, 32'h00010000, q);
        repeat (4) @(posedge core_clk);
    endtask
    task automatic wipe;
        @(posedge core_clk);
        nv_wipe <= 1'b1;
        @(posedge core_clk);
        nv_wipe <= 1'b0;
    endtask
    // Loads parameters, issues a command, polls for idle
    task automatic run(input logic [7:0] op, input logic [7:0] ds,
                       input logic [15:0] ctl, input logic [15:0] rv,
                       input logic [7:0] key, input logic bad,
                       output logic [31:0] st);
        logic [31:0] q;
        int n = 0;
        wb(1'b1, REG_PARM, {rv, ctl}, q);
        for (int i = 0; i < PW_WORDS; i++)
            wb(1'b1, REG_PW_BASE + 8'(4 * i), {16'h0,
               key ^ {bad && i == 15, 7'h00}, 8'(i)}, q);
        wb(1'b1, REG_CMD, {16'h0, ds, op}, q);
        do begin
            wb(1'b0, REG_STAT, 32'h0, st);
            n++;
        end while (st[0] !== 1'b0 && n < 200);
        if (n >= 200) begin
            chk(1'b0, "command never finished");
            finish_test();
        end
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] st;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        wipe();
        foreach (ROWS[k]) begin
            if (ROWS[k].hr)
                hard_rst();
            run(ROWS[k].op, DEVSEL_ONES, ROWS[k].ctl, ROWS[k].rv,
                ROWS[k].key, ROWS[k].bad, st);
            chk(st[2] === ROWS[k].command_aborted_flag && st[3] === ROWS[k].command_aborted_flag, "abort");
            chk(locked === ROWS[k].lk, "lock state");
            chk(lock_enabled === ROWS[k].le, "lock enable");
            chk(tries_left === ROWS[k].tr, "attempts");
            chk(rev_code === 16'h1234, "revision");
        end
        chk(max_level === 1'b1, "maximum level");
        // Five mismatches exhaust the attempts
        for (int i = 0; i < 5; i++) begin
            run(CMD_UNLOCK, DEVSEL_ONES, 16'h0, 16'h0, KB, 1'b1, st);
            chk(tries_left === 3'(4 - i), "count down");
        end
        run(CMD_UNLOCK, DEVSEL_ONES, 16'h0, 16'h0, KB, 1'b0, st);
        chk(st[4] === 1'b1 && locked === 1'b1, "exhausted");
        run(CMD_SET_PW, DEVSEL_ONES, 16'h1, 16'h0, KA, 1'b0, st);
        chk(st[4] === 1'b1, "set when exhausted");
        hard_rst();
        @(posedge core_clk);
        frozen <= 1'b1;
        run(CMD_UNLOCK, DEVSEL_ONES, 16'h0, 16'h0, KB, 1'b0, st);
        chk(st[4] === 1'b1 && tries_left === 3'h5, "frozen");
        frozen <= 1'b0;
        run(CMD_UNLOCK, 8'h00, 16'h0, 16'h0, KB, 1'b0, st);
        chk(st[4] === 1'b1 && locked === 1'b1, "device select");
        run(8'h55, DEVSEL_ONES, 16'h0, 16'h0, KB, 1'b0, st);
        chk(st[4] === 1'b1, "bad opcode");
        run(CMD_UNLOCK, DEVSEL_ONES, 16'h0, 16'h0, KB, 1'b1, st);
        // A reset after the mismatch has completed reloads the count, keeps the store
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        chk(tries_left === 3'h5 && locked === 1'b1, "reset relock");
        chk(lock_enabled === 1'b1 && rev_code === 16'h1234, "store kept");
        wb(1'b0, 8'hfc, 32'h0, st);
        chk(st === 32'h0, "unmapped read");
        // User unlock with locking disabled
        wipe();
        hard_rst();
        run(CMD_UNLOCK, DEVSEL_ONES, 16'h0, 16'h0, KB, 1'b0, st);
        chk(st[2] === 1'b1 && locked === 1'b0, "lock disabled");
        finish_test();
    end
endmodule
